//--- hw/lsf_consts.vh
// Constants for the LIN status and error flag block
`ifndef LSF_CONSTS_VH
`define LSF_CONSTS_VH
// Indirect register addresses
`define LSF_ADDR_CONTROL      4'h8
`define LSF_ADDR_STATUS       4'h9
`define LSF_ADDR_ERROR        4'hA
// Control register bit positions
`define LSF_CTRL_STOP         7
`define LSF_CTRL_DTACK        4
`define LSF_CTRL_CLR_INT      3
`define LSF_CTRL_CLR_ERR      2
// Status register bit positions
`define LSF_ST_ACTIVE         7
`define LSF_ST_IDLE_TIMEOUT_ERROR      6
`define LSF_ST_ABORT          5
`define LSF_ST_DATA_REQ       4
`define LSF_ST_INT_PEND       3
`define LSF_ST_ERROR          2
`define LSF_ST_WAKEUP         1
`define LSF_ST_DONE           0
// Error register bit positions
`define LSF_ERR_SYNC          4
`define LSF_ERR_PARITY        3
`define LSF_ERR_TIMEOUT       2
`define LSF_ERR_CHECKSUM      1
`define LSF_ERR_BIT           0
// Reset values
`define LSF_STATUS_RST        8'h00
`define LSF_ERROR_RST         5'h00
// Timing: clock rate, idle timeout and tick period
`define LSF_CLK_KHZ           250000
`define LSF_IDLE_TIMEOUT_MS   4000
`define LSF_TICK_MS           1
`endif

//--- hw/lsf_idle_timer.v
// Bus idle timer built from a millisecond tick divider and a tick counter
`timescale 1ns/1ps
`include "lsf_consts.vh"
module lsf_idle_timer #(
   parameter TICK_CYCLES = `LSF_CLK_KHZ * `LSF_TICK_MS,
   parameter TICKS       = `LSF_IDLE_TIMEOUT_MS / `LSF_TICK_MS
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        restart,
   output reg         expired_r
);
   reg  [31:0] div_r;
   reg  [31:0] ticks_r;
   wire        tick;

   // One-cycle enable every tick period
   assign tick = (div_r == TICK_CYCLES - 1);

   // Divider and tick counter, both restarted by bus activity
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_r     <= 32'h00000000;
         ticks_r   <= 32'h00000000;
         expired_r <= 1'b0;
      end else if (restart) begin
         div_r     <= 32'h00000000;
         ticks_r   <= 32'h00000000;
         expired_r <= 1'b0;
      end else if (tick) begin
         div_r <= 32'h00000000;
         if (ticks_r == TICKS - 1) begin
            expired_r <= 1'b1;
         end else begin
            ticks_r <= ticks_r + 32'h00000001;
         end
      end else begin
         div_r <= div_r + 32'h00000001;
      end
   end
endmodule // lsf_idle_timer

//--- hw/lsf_status_flags.v
// LIN status and error flag registers with indirect read and control strobes
`timescale 1ns/1ps
`include "lsf_consts.vh"

module lsf_status_flags #(
   parameter TICK_CYCLES = `LSF_CLK_KHZ * `LSF_TICK_MS,
   parameter IDLE_TICKS  = `LSF_IDLE_TIMEOUT_MS / `LSF_TICK_MS
) (
   input  wire        clk,
   input  wire        resetn,
   // Indirect register access
   input  wire [3:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_r,
   // Bus pin and mode
   input  wire        lin_rx,
   input  wire        master_mode,
   input  wire        sleep_state,
   // Frame engine events, same clock
   input  wire        frame_busy,
   input  wire        frame_start,
   input  wire        frame_done,
   input  wire        break_seen,
   input  wire        id_received,
   input  wire        wakeup_tx_active,
   input  wire        wakeup_rx,
   input  wire        sync_field_error,
   input  wire        parity_error,
   input  wire        timeout_error,
   input  wire        checksum_error,
   input  wire        bit_mismatch_error,
   // Flag outputs
   output reg         comm_blocked_r,
   output reg         interrupt_pending_flag_r,
   output reg         data_request_flag_r
);
   reg  [1:0] rx_sync_r;
   reg        active_r;
   reg        bus_idle_timeout_flag_r;
   reg        abort_r;
   reg        error_sum_r;
   reg        wakeup_rx_r;
   reg        wakeup_r;
   reg        done_r;
   reg  [4:0] lin_error_flags_r;
   reg  [4:0] lin_error_flags_nxt;
   wire       slave;
   wire       ctrl_wr;
   wire       stop_wr;
   wire       clear_interrupt_strobe;
   wire       clear_error_strobe;
   wire       dtack_wr;
   wire       busy_now;
   wire       break_abort;
   wire       idle_expired;
   wire [4:0] err_events;
   wire       any_err;
   wire       int_event;
   wire [7:0] status_word;

   // Decode of one strobe bit of a control write; the strobes
   // exist only for the cycle of the write and never read back
   function ctrl_strobe;
      input         wr_ctrl;
      input [7:0]   wdata;
      input integer pos;
      begin
         ctrl_strobe = wr_ctrl & wdata[pos];
      end
   endfunction

   // Decode of control writes
   assign slave                  = ~master_mode;
   assign ctrl_wr                = reg_wr & (reg_addr == `LSF_ADDR_CONTROL);
   assign stop_wr                = ctrl_wr & reg_wdata[`LSF_CTRL_STOP] & slave;
   assign clear_interrupt_strobe = ctrl_strobe(ctrl_wr, reg_wdata, `LSF_CTRL_CLR_INT);
   assign clear_error_strobe     = ctrl_strobe(ctrl_wr, reg_wdata, `LSF_CTRL_CLR_ERR);
   assign dtack_wr               = ctrl_strobe(ctrl_wr, reg_wdata, `LSF_CTRL_DTACK);

   // Error events gathered in register bit order
   assign err_events = {sync_field_error & slave, parity_error & slave, timeout_error,
                        checksum_error, bit_mismatch_error};
   assign any_err    = |err_events;
   assign busy_now   = ~rx_sync_r[1] | frame_busy;
   assign int_event  = frame_done | (id_received & slave) | any_err | wakeup_rx
                     | break_abort;

   // Break that cuts a pending slave frame; aborts it and interrupts
   assign break_abort = break_seen & frame_busy & slave;

   // Pin synchroniser, two stages
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_sync_r <= 2'h3;
      end else begin
         rx_sync_r <= {rx_sync_r[0], lin_rx};
      end
   end

   // Quiet-bus timer
   // Activity restarts it, so the idle flag drops two cycles after busy_now rises
   lsf_idle_timer #(
      .TICK_CYCLES (TICK_CYCLES),
      .TICKS       (IDLE_TICKS)
   ) u_idle (
      .clk       (clk),
      .resetn    (resetn),
      .restart   (busy_now),
      .expired_r (idle_expired)
   );

   // Error flags: set wins over clear
   // A clear wipes old flags, then this cycle's events are merged back in
   always @* begin
      lin_error_flags_nxt = lin_error_flags_r;
      if (clear_error_strobe) begin
         lin_error_flags_nxt = `LSF_ERROR_RST;
      end
      lin_error_flags_nxt = lin_error_flags_nxt | err_events;
   end

   // Status flags
   // Set conditions are tested first, except the break clear of comm_blocked_r, so only abort_r's break clear can lose to a strobe (stop_wr)
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_r                 <= 1'b0;
         bus_idle_timeout_flag_r  <= 1'b0;
         abort_r                  <= 1'b0;
         data_request_flag_r      <= 1'b0;
         interrupt_pending_flag_r <= 1'b0;
         error_sum_r              <= 1'b0;
         wakeup_rx_r              <= 1'b0;
         wakeup_r                 <= 1'b0;
         done_r                   <= 1'b0;
         comm_blocked_r           <= 1'b0;
         lin_error_flags_r        <= `LSF_ERROR_RST;
      end else begin
         active_r <= busy_now;
         bus_idle_timeout_flag_r <= slave & idle_expired & ~sleep_state;
         lin_error_flags_r <= lin_error_flags_nxt;
         // Abort flag
         if (break_abort | stop_wr) begin
            abort_r <= 1'b1;
         end else if (break_seen & ~frame_busy) begin
            abort_r <= 1'b0;
         end
         // Data request, dropped by acknowledge, a new frame or master mode
         if (id_received & slave) begin
            data_request_flag_r <= 1'b1;
         end else if (dtack_wr | frame_start | master_mode) begin
            data_request_flag_r <= 1'b0;
         end
         // Interrupt pending: event wins over the strobe
         if (int_event) begin
            interrupt_pending_flag_r <= 1'b1;
         end else if (clear_interrupt_strobe) begin
            interrupt_pending_flag_r <= 1'b0;
         end
         // Error summary: event wins over the strobe
         if (any_err) begin
            error_sum_r <= 1'b1;
         end else if (clear_error_strobe) begin
            error_sum_r <= 1'b0;
         end
         // Received wakeup held until the next frame
         if (wakeup_rx) begin
            wakeup_rx_r <= 1'b1;
         end else if (frame_start) begin
            wakeup_rx_r <= 1'b0;
         end
         wakeup_r <= wakeup_tx_active | wakeup_rx | wakeup_rx_r;
         // Completion flag
         if (frame_done) begin
            done_r <= 1'b1;
         end else if (frame_start) begin
            done_r <= 1'b0;
         end
         // Communication block until next break
         if (break_seen) begin
            comm_blocked_r <= 1'b0;
         end else if (stop_wr) begin
            comm_blocked_r <= 1'b1;
         end
      end
   end

   assign status_word = {active_r, bus_idle_timeout_flag_r, abort_r, data_request_flag_r,
                         interrupt_pending_flag_r, error_sum_r, wakeup_r, done_r};

   // Registered read; control strobes read as zero
   // Sees the flags as they stood before this edge's updates
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `LSF_ADDR_STATUS: reg_rdata_r <= status_word;
            `LSF_ADDR_ERROR:  reg_rdata_r <= {3'h0, lin_error_flags_r};
            default:          reg_rdata_r <= 8'h00;
         endcase
      end
   end
endmodule // lsf_status_flags

//--- dv/lsf_status_flags_assertions.sv
// Port-level checks on the LIN status flag block
`timescale 1ns/1ps
`include "lsf_consts.vh"
module lsf_status_flags_assertions (
   input wire       clk,
   input wire       resetn,
   input wire [3:0] reg_addr,
   input wire       reg_wr,
   input wire [7:0] reg_wdata,
   input wire       reg_rd,
   input wire [7:0] reg_rdata_r,
   input wire       master_mode,
   input wire       frame_done,
   input wire       break_seen,
   input wire       id_received,
   input wire       comm_blocked_r,
   input wire       interrupt_pending_flag_r,
   input wire       data_request_flag_r
);
   // Control write decode
   wire ctl_wr = reg_wr && (reg_addr == `LSF_ADDR_CONTROL);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_int_on_done: assert property (frame_done |=> interrupt_pending_flag_r)
      else $error("pending flag missed a frame end");
   chk_int_holds: assert property (
      interrupt_pending_flag_r && !(ctl_wr && reg_wdata[3]) |=> interrupt_pending_flag_r)
      else $error("pending flag dropped unasked");
   chk_dreq_set: assert property (id_received && !master_mode |=> data_request_flag_r)
      else $error("data request not raised");
   chk_dreq_master: assert property (master_mode |=> !data_request_flag_r)
      else $error("data request high in master mode");
   chk_stop_blocks: assert property (
      ctl_wr && reg_wdata[7] && !master_mode && !break_seen |=> comm_blocked_r)
      else $error("stop did not block");
   chk_break_frees: assert property (break_seen |=> !comm_blocked_r)
      else $error("break did not release block");
   chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_r))
      else $error("read data moved without a read");
   chk_err_upper: assert property (
      reg_rd && reg_addr == `LSF_ADDR_ERROR |=> reg_rdata_r[7:5] == 3'h0)
      else $error("error register top bits set");
   chk_int_mirror: assert property (
      reg_rd && reg_addr == `LSF_ADDR_STATUS
      |=> reg_rdata_r[3] == $past(interrupt_pending_flag_r)) else $error("bit 3 mismatch");
   chk_strobes_zero: assert property (
      reg_rd && reg_addr == `LSF_ADDR_CONTROL |=> reg_rdata_r[3:2] == 2'h0)
      else $error("strobes read nonzero");
endmodule // lsf_status_flags_assertions
bind lsf_status_flags lsf_status_flags_assertions lsf_status_flags_assertions_i (.clk, .resetn,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_r, .master_mode, .frame_done,
   .break_seen, .id_received, .comm_blocked_r, .interrupt_pending_flag_r, .data_request_flag_r);

//--- dv/lsf_bus_node.sv
// Other LIN node that pulls the bus dominant on command
`timescale 1ns/1ps
module lsf_bus_node (
   input  wire clk,
   input  wire send,
   output wire lin_rx
);
   reg [3:0] cnt_r = 4'h0;
   // Ten dominant cycles per send, pulled-up recessive otherwise
   always @(posedge clk) begin
      cnt_r <= send ? 4'hA : cnt_r - {3'h0, cnt_r != 4'h0};
   end
   assign lin_rx = (cnt_r == 4'h0);
endmodule // lsf_bus_node

//--- dv/lsf_status_flags_test.sv
// Register-level test of the LIN status flag block
`timescale 1ns/1ps
module lsf_status_flags_test;
   reg        clk, resetn, reg_wr, reg_rd, master_mode, frame_busy, wakeup_tx_active, send;
   reg        sleep_state;
   reg [3:0]  reg_addr;
   reg [7:0]  reg_wdata, exp_err;
   reg [9:0]  ev;
   wire [7:0] reg_rdata_r;
   wire       lin_rx, comm_blocked_r, int_f, dreq_f;
   integer    failures, comparisons, i;
   lsf_bus_node lsf_bus_node_i (.clk(clk), .send(send), .lin_rx(lin_rx));
   lsf_status_flags #(.TICK_CYCLES(4), .IDLE_TICKS(5)) lsf_status_flags_i (.clk(clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .lin_rx(lin_rx), .master_mode(master_mode),
      .sleep_state(sleep_state), .frame_busy(frame_busy), .frame_start(ev[0]),
      .frame_done(ev[1]),
      .break_seen(ev[2]), .id_received(ev[3]), .wakeup_tx_active(wakeup_tx_active),
      .wakeup_rx(ev[4]), .sync_field_error(ev[5]), .parity_error(ev[6]),
      .timeout_error(ev[7]), .checksum_error(ev[8]), .bit_mismatch_error(ev[9]),
      .comm_blocked_r(comm_blocked_r), .interrupt_pending_flag_r(int_f),
      .data_request_flag_r(dreq_f));
   // Compare and count
   task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
      begin
         comparisons = comparisons + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s exp %h seen %h", nm, e, s);
         end
      end
   endtask
   // Indirect read, masked compare after the answer edge
   task rd(input [63:0] nm, input [3:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 chk(nm, reg_rdata_r & m, e & m);
      end
   endtask
   // Control register write
   task wr(input [7:0] d);
      begin
         @(posedge clk);
         reg_addr <= 4'h8;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   // One-cycle event pulse
   task pulse(input integer n);
      begin
         @(posedge clk);
         ev <= 10'h001 << n;
         @(posedge clk);
         ev <= 10'h000;
         #1;
      end
   endtask
   task finish_test;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      failures = failures + 1;
      finish_test;
   end
   // Test sequence
   initial begin
      {resetn, reg_wr, reg_rd, master_mode, frame_busy, wakeup_tx_active, send} = 7'h00;
      sleep_state = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      ev = 10'h000;
      exp_err = 8'h00;
      failures = 0;
      comparisons = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd("status", 4'h9, 8'hFF, 8'h00);
      rd("errors", 4'hA, 8'hFF, 8'h00);
      rd("unmapped", 4'hB, 8'hFF, 8'h00);
      $display("reset test done");
      for (i = 5; i < 10; i = i + 1) begin
         pulse(i);
         exp_err = exp_err | (8'h01 << (9 - i));
         rd("errors", 4'hA, 8'hFF, exp_err);
      end
      rd("status", 4'h9, 8'h0C, 8'h0C);
      wr(8'h04);
      rd("errors", 4'hA, 8'hFF, 8'h00);
      rd("status", 4'h9, 8'h0C, 8'h08);
      wr(8'h08);
      chk("intpend", {7'h00, int_f}, 8'h00);
      rd("status", 4'h9, 8'h08, 8'h00);
      pulse(1);
      wr(8'h00);
      rd("status", 4'h9, 8'h09, 8'h09);
      rd("control", 4'h8, 8'h8C, 8'h00);
      $display("error test done");
      @(posedge clk) master_mode <= 1'b1;
      pulse(6);
      pulse(3);
      wr(8'h80);
      chk("blocked", {7'h00, comm_blocked_r}, 8'h00);
      rd("errors", 4'hA, 8'h1F, 8'h00);
      rd("status", 4'h9, 8'h10, 8'h00);
      @(posedge clk) master_mode <= 1'b0;
      pulse(0);
      rd("status", 4'h9, 8'h01, 8'h00);
      pulse(3);
      rd("status", 4'h9, 8'h10, 8'h10);
      chk("dreq", {7'h00, dreq_f}, 8'h01);
      wr(8'h10);
      rd("status", 4'h9, 8'h10, 8'h00);
      $display("frame test done");
      @(posedge clk) frame_busy <= 1'b1;
      pulse(2);
      rd("status", 4'h9, 8'h20, 8'h20);
      @(posedge clk) frame_busy <= 1'b0;
      pulse(2);
      rd("status", 4'h9, 8'h20, 8'h00);
      wr(8'h80);
      chk("blocked", {7'h00, comm_blocked_r}, 8'h01);
      rd("status", 4'h9, 8'h20, 8'h20);
      pulse(2);
      chk("blocked", {7'h00, comm_blocked_r}, 8'h00);
      $display("abort test done");
      @(posedge clk) wakeup_tx_active <= 1'b1;
      rd("status", 4'h9, 8'h02, 8'h02);
      @(posedge clk) wakeup_tx_active <= 1'b0;
      rd("status", 4'h9, 8'h02, 8'h00);
      pulse(4);
      rd("status", 4'h9, 8'h02, 8'h02);
      pulse(0);
      rd("status", 4'h9, 8'h02, 8'h00);
      $display("wakeup test done");
      repeat (30) @(posedge clk);
      rd("status", 4'h9, 8'h40, 8'h40);
      @(posedge clk) sleep_state <= 1'b1;
      rd("status", 4'h9, 8'h40, 8'h00);
      @(posedge clk) sleep_state <= 1'b0;
      @(posedge clk) send <= 1'b1;
      @(posedge clk) send <= 1'b0;
      repeat (3) @(posedge clk);
      rd("status", 4'h9, 8'hC0, 8'h80);
      repeat (20) @(posedge clk);
      rd("status", 4'h9, 8'h80, 8'h00);
      $display("activity test done");
      finish_test;
   end
endmodule // lsf_status_flags_test
